// ==== shared/plc_pkg.sv ====
// Shared constants and types of the programmable logic and counter engine
`default_nettype none

package plc_pkg;

  // ****************************************************************
  // Structure of a logic variable
  // ****************************************************************
  localparam int NUM_STAGE = 5;
  localparam int MAX_VAR_INPUTS = 10;
  localparam int OP_W = 4;

  typedef enum logic [OP_W-1:0] {
    PLC_OP_NONE,
    PLC_OP_OR,
    PLC_OP_NOR,
    PLC_OP_AND,
    PLC_OP_NAND,
    PLC_OP_XOR,
    PLC_OP_XNOR,
    PLC_OP_NOT,
    PLC_OP_RESET_DOMINANT_LATCH,
    PLC_OP_SET_DOMINANT_LATCH,
    PLC_OP_TOGGLE
  } plc_op_t;

  // ****************************************************************
  // Counters
  // ****************************************************************
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFFFFFF;
  localparam logic [CNT_W-1:0] CNT_ALARM_DEFAULT = 32'h000007D0;
  localparam logic [CNT_W-1:0] CNT_PRESET_DEFAULT = 32'h00000000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int CYCLE_TIME_NS = 1000;
  localparam int CYCLE_CLKS = CYCLE_TIME_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Default port counts
  // ****************************************************************
  localparam int DFLT_NUM_PROT = 8;
  localparam int DFLT_NUM_KEY = 4;
  localparam int DFLT_NUM_DI = 10;
  localparam int DFLT_NUM_VI = 4;
  localparam int DFLT_NUM_COMM = 4;
  localparam int DFLT_NUM_VAR = 4;
  localparam int DFLT_NUM_CNT = 2;
  localparam int DFLT_NUM_ROUTE = 8;

endpackage

`default_nettype wire

// ==== core/plc_logic_engine.sv ====
// User programmable logic chains, event counters and signal routing
`default_nettype none

// Functional notes
// - Every protection and control output can be picked as a logic source.
// - Each function key signal can feed any logic variable input.
// - Selected internal signals are routed to control, block and comm inputs.
// - Combined trip is high whenever any protection trips.
// - Combined blocked is high whenever any protection is blocked.
// - Stage op: none, OR, NOR, AND, NAND, XOR, XNOR, NOT, latches, toggle.
// - First stage primary input is freely selected; it is the set input in latches.
// - First stage second input is selectable, unused for NOT and toggle.
// - Stages two to five take the previous stage output as first input.
// - Stages two to five second input selectable, ignored for NOT and toggle.
// - Counter picks its source and adds one on each count pulse.
// - A clear pulse loads the counter with the preset value.
// - Counter is unsigned 32-bit and saturates at its maximum.
// - Alarm is high while count is at or above the threshold.
// - Alarm threshold is configurable, defaulting to 2000.
// - Clear preset is configurable, defaulting to zero.
// - A logic variable uses at most ten inputs in total.
// - Reset-dominant latch sets, clears, holds, and goes low on both high.
// - Set-dominant latch is the same but goes high on both high.
// - Toggle inverts on each strobe with input high, holds when low.
module plc_logic_engine #(
  parameter int NUM_PROT = plc_pkg::DFLT_NUM_PROT,
  parameter int NUM_KEY = plc_pkg::DFLT_NUM_KEY,
  parameter int NUM_DI = plc_pkg::DFLT_NUM_DI,
  parameter int NUM_VI = plc_pkg::DFLT_NUM_VI,
  parameter int NUM_COMM = plc_pkg::DFLT_NUM_COMM,
  parameter int NUM_VAR = plc_pkg::DFLT_NUM_VAR,
  parameter int NUM_CNT = plc_pkg::DFLT_NUM_CNT,
  parameter int NUM_ROUTE = plc_pkg::DFLT_NUM_ROUTE,
  parameter int CYCLE_CLKS = plc_pkg::CYCLE_CLKS,
  localparam int NS = plc_pkg::NUM_STAGE,
  localparam int OPW = plc_pkg::OP_W,
  localparam int CW = plc_pkg::CNT_W,
  localparam int SRC_W = NUM_PROT + NUM_KEY + NUM_DI + NUM_VI + NUM_COMM
                         + 2 + NUM_VAR + NUM_CNT,
  localparam int SELW = $clog2(SRC_W)
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [NUM_PROT-1:0] prot_out_i,
  input wire logic [NUM_PROT-1:0] prot_trip_i,
  input wire logic [NUM_PROT-1:0] prot_blocked_i,
  input wire logic [NUM_KEY-1:0] fkey_i,
  input wire logic [NUM_DI-1:0] dig_in_i,
  input wire logic [NUM_VI-1:0] virt_in_i,
  input wire logic [NUM_COMM-1:0] comm_in_i,
  input wire logic [NUM_VAR-1:0] var_en_i,
  input wire logic [NUM_VAR*NS*OPW-1:0] stage_op_i,
  input wire logic [NUM_VAR*SELW-1:0] first_sel_i,
  input wire logic [NUM_VAR*NS*SELW-1:0] second_sel_i,
  input wire logic [NUM_CNT*SELW-1:0] cnt_src_sel_i,
  input wire logic [NUM_CNT*SELW-1:0] cnt_clr_sel_i,
  input wire logic [NUM_CNT-1:0] cnt_custom_i,
  input wire logic [NUM_CNT*CW-1:0] cnt_alarm_thr_i,
  input wire logic [NUM_CNT*CW-1:0] cnt_preset_i,
  input wire logic [NUM_ROUTE*SELW-1:0] route_sel_i,
  output logic [NUM_VAR-1:0] var_out_o,
  output logic [NUM_CNT*CW-1:0] cnt_value_o,
  output logic [NUM_CNT-1:0] cnt_alarm_o,
  output logic any_trip_o,
  output logic any_blocked_o,
  output logic [NUM_ROUTE-1:0] route_o,
  output logic cycle_strobe_o
);

  localparam int DIVW = $clog2(CYCLE_CLKS);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (NS + 1 > plc_pkg::MAX_VAR_INPUTS) begin : g_chk_inputs
    $error("Too many inputs per logic variable");
  end
  if (CYCLE_CLKS < 2) begin : g_chk_cycle
    $error("CYCLE_CLKS must be at least 2");
  end
  if (NUM_VAR < 1 || NUM_CNT < 1 || NUM_ROUTE < 1) begin : g_chk_counts
    $error("NUM_VAR, NUM_CNT and NUM_ROUTE must be at least 1");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [NUM_DI-1:0] di_s1;
    logic [NUM_DI-1:0] di_s2;
    logic [NUM_DI-1:0] di_s3;
    logic [NUM_DI-1:0] di_st;
    logic [NUM_KEY-1:0] key_s1;
    logic [NUM_KEY-1:0] key_s2;
    logic [NUM_KEY-1:0] key_s3;
    logic [NUM_KEY-1:0] key_st;
    logic [DIVW-1:0] div;
    logic strobe;
    logic [NUM_VAR*NS-1:0] stq;
    logic [NUM_VAR-1:0] var_out;
    logic [NUM_CNT-1:0][CW-1:0] cnt;
    logic [NUM_CNT-1:0] up_prev;
    logic [NUM_CNT-1:0] clr_prev;
    logic [NUM_CNT-1:0] alarm;
    logic any_trip;
    logic any_blk;
    logic [NUM_ROUTE-1:0] route;
  } plc_state_t;

  plc_state_t st_reg;
  plc_state_t st_next;
  logic [SRC_W-1:0] src_w;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic pick(input logic [SRC_W-1:0] vec,
                                input logic [SELW-1:0] idx);
    logic r;
    r = 1'b0;
    if (int'(idx) < SRC_W) begin
      r = vec[idx];
    end
    return r;
  endfunction

  // Second input b is ignored by NOT and toggle, a is set in latches
  function automatic logic stage_eval(input logic [OPW-1:0] op,
                                      input logic a,
                                      input logic b,
                                      input logic q);
    logic r;
    r = a;
    case (op)
      plc_pkg::PLC_OP_NONE: r = a;
      plc_pkg::PLC_OP_OR: r = a | b;
      plc_pkg::PLC_OP_NOR: r = ~(a | b);
      plc_pkg::PLC_OP_AND: r = a & b;
      plc_pkg::PLC_OP_NAND: r = ~(a & b);
      plc_pkg::PLC_OP_XOR: r = a ^ b;
      plc_pkg::PLC_OP_XNOR: r = ~(a ^ b);
      plc_pkg::PLC_OP_NOT: r = ~a;
      plc_pkg::PLC_OP_RESET_DOMINANT_LATCH: r = ~b & (a | q);
      plc_pkg::PLC_OP_SET_DOMINANT_LATCH: r = a | (~b & q);
      plc_pkg::PLC_OP_TOGGLE: r = a ? ~q : q;
      default: r = a;
    endcase
    return r;
  endfunction

  // Registered variable and alarm outputs feed back as sources, which
  // keeps the selection free of combinational loops at one cycle's cost
  assign src_w = {st_reg.alarm, st_reg.var_out, st_reg.any_blk,
                  st_reg.any_trip, comm_in_i, prot_out_i, virt_in_i,
                  st_reg.key_st, st_reg.di_st};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic chain_v;
    logic a_v;
    logic b_v;
    logic r_v;
    logic up_v;
    logic clr_v;
    logic [CW-1:0] thr_v;
    logic [CW-1:0] pre_v;
    int i;
    chain_v = 1'b0;
    a_v = 1'b0;
    b_v = 1'b0;
    r_v = 1'b0;
    up_v = 1'b0;
    clr_v = 1'b0;
    thr_v = '0;
    pre_v = '0;
    i = 0;
    st_next = st_reg;

    // Pins: a change counts once the second and third stages agree
    st_next.di_s1 = dig_in_i;
    st_next.di_s2 = st_reg.di_s1;
    st_next.di_s3 = st_reg.di_s2;
    st_next.di_st = (~(st_reg.di_s2 ^ st_reg.di_s3) & st_reg.di_s3)
                  | ((st_reg.di_s2 ^ st_reg.di_s3) & st_reg.di_st);
    st_next.key_s1 = fkey_i;
    st_next.key_s2 = st_reg.key_s1;
    st_next.key_s3 = st_reg.key_s2;
    st_next.key_st = (~(st_reg.key_s2 ^ st_reg.key_s3) & st_reg.key_s3)
                   | ((st_reg.key_s2 ^ st_reg.key_s3) & st_reg.key_st);

    // Real-time cycle divider
    st_next.strobe = (st_reg.div == DIVW'(CYCLE_CLKS - 1));
    st_next.div = st_next.strobe ? '0 : st_reg.div + 1'b1;

    st_next.any_trip = |prot_trip_i;
    st_next.any_blk = |prot_blocked_i;

    for (int r = 0; r < NUM_ROUTE; r++) begin
      st_next.route[r] = pick(src_w, route_sel_i[r*SELW +: SELW]);
    end

    // Logic chains, evaluated stage after stage within one strobe
    for (int v = 0; v < NUM_VAR; v++) begin
      chain_v = 1'b0;
      for (int s = 0; s < NS; s++) begin
        i = v * NS + s;
        if (s == 0) begin
          a_v = pick(src_w, first_sel_i[v*SELW +: SELW]);
        end else begin
          a_v = chain_v;
        end
        b_v = pick(src_w, second_sel_i[i*SELW +: SELW]);
        r_v = stage_eval(stage_op_i[i*OPW +: OPW], a_v, b_v, st_reg.stq[i]);
        if (!var_en_i[v]) begin
          st_next.stq[i] = 1'b0;
        end else if (st_reg.strobe) begin
          st_next.stq[i] = r_v;
        end
        chain_v = r_v;
      end
      if (!var_en_i[v]) begin
        st_next.var_out[v] = 1'b0;
      end else if (st_reg.strobe) begin
        st_next.var_out[v] = chain_v;
      end
    end

    // Counters
    for (int c = 0; c < NUM_CNT; c++) begin
      up_v = pick(src_w, cnt_src_sel_i[c*SELW +: SELW]);
      clr_v = pick(src_w, cnt_clr_sel_i[c*SELW +: SELW]);
      thr_v = cnt_custom_i[c] ? cnt_alarm_thr_i[c*CW +: CW]
                              : plc_pkg::CNT_ALARM_DEFAULT;
      pre_v = cnt_custom_i[c] ? cnt_preset_i[c*CW +: CW]
                              : plc_pkg::CNT_PRESET_DEFAULT;
      if (st_reg.strobe) begin
        st_next.up_prev[c] = up_v;
        st_next.clr_prev[c] = clr_v;
        // Clear outranks a count pulse seen in the same cycle
        if (clr_v && !st_reg.clr_prev[c]) begin
          st_next.cnt[c] = pre_v;
        end else if (up_v && !st_reg.up_prev[c]
                     && st_reg.cnt[c] != plc_pkg::CNT_MAX) begin
          st_next.cnt[c] = st_reg.cnt[c] + 1'b1;
        end
      end
      st_next.alarm[c] = (st_next.cnt[c] >= thr_v);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign var_out_o = st_reg.var_out;
  assign cnt_value_o = st_reg.cnt;
  assign cnt_alarm_o = st_reg.alarm;
  assign any_trip_o = st_reg.any_trip;
  assign any_blocked_o = st_reg.any_blk;
  assign route_o = st_reg.route;
  assign cycle_strobe_o = st_reg.strobe;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic trip_any_w;
  logic blk_any_w;
  logic route0_w;
  logic up0_edge_w;
  logic clr0_edge_w;
  logic [CW-1:0] thr0_w;
  logic [CW-1:0] pre0_w;
  assign trip_any_w = |prot_trip_i;
  assign blk_any_w = |prot_blocked_i;
  assign route0_w = pick(src_w, route_sel_i[SELW-1:0]);
  assign up0_edge_w = pick(src_w, cnt_src_sel_i[0+:SELW]) & ~st_reg.up_prev[0];
  assign clr0_edge_w = pick(src_w, cnt_clr_sel_i[SELW-1:0])
                       & ~st_reg.clr_prev[0];
  assign thr0_w = cnt_custom_i[0] ? cnt_alarm_thr_i[CW-1:0]
                                  : plc_pkg::CNT_ALARM_DEFAULT;
  assign pre0_w = cnt_custom_i[0] ? cnt_preset_i[CW-1:0]
                                  : plc_pkg::CNT_PRESET_DEFAULT;

  property p_trip;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      1'b1 |=> any_trip_o == $past(trip_any_w);
  endproperty
  a_trip: assert property (p_trip)
    else $error("Combined trip does not follow protection trips");

  property p_blocked;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      1'b1 |=> any_blocked_o == $past(blk_any_w);
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("Combined blocked does not follow protection blocks");

  property p_route;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      1'b1 |=> route_o[0] == $past(route0_w);
  endproperty
  a_route: assert property (p_route)
    else $error("Routed output differs from its selected source");

  property p_clear;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      cycle_strobe_o && clr0_edge_w |=> cnt_value_o[CW-1:0] == $past(pre0_w);
  endproperty
  a_clear: assert property (p_clear)
    else $error("Clear pulse did not load the preset");

  property p_count;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      cycle_strobe_o && up0_edge_w && !clr0_edge_w
      && cnt_value_o[CW-1:0] != plc_pkg::CNT_MAX
      |=> cnt_value_o[CW-1:0] == $past(cnt_value_o[CW-1:0]) + 32'h00000001;
  endproperty
  a_count: assert property (p_count)
    else $error("Count pulse did not add one");
  property p_saturate;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      cnt_value_o[CW-1:0] == plc_pkg::CNT_MAX
      && !(cycle_strobe_o && clr0_edge_w)
      |=> cnt_value_o[CW-1:0] == plc_pkg::CNT_MAX;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("Counter left its maximum without a clear");

  property p_alarm;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      1'b1 |=> cnt_alarm_o[0] == (cnt_value_o[CW-1:0] >= $past(thr0_w));
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("Alarm disagrees with count and threshold");

  property p_disabled;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !var_en_i[0] |=> !var_out_o[0];
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("Disabled variable drives its output high");

  property p_hold_between;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      var_en_i[0] && !cycle_strobe_o ##1 var_en_i[0] |-> $stable(var_out_o[0]);
  endproperty
  a_hold_between: assert property (p_hold_between)
    else $error("Variable output changed outside the cycle strobe");

  property p_strobe_gap;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      cycle_strobe_o |=> !cycle_strobe_o;
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("Cycle strobe lasted more than one clock");

endmodule

`default_nettype wire

// ==== tb/plc_src_model.sv ====
// Behavioural model of the signal sources that feed the logic engine
`default_nettype none

module plc_src_model (
  input wire logic sys_clk_i,
  input wire logic [45:0] cmd_i,
  output logic [9:0] dig_in_o = 10'h000,
  output logic [3:0] fkey_o = 4'h0,
  output logic [3:0] virt_in_o = 4'h0,
  output logic [7:0] prot_out_o = 8'h00,
  output logic [3:0] comm_in_o = 4'h0,
  output logic [7:0] prot_trip_o = 8'h00,
  output logic [7:0] prot_blocked_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;

  // Command bits 0 to 29 follow the engine's source order, so bit j is source j; bits 30 to 45 drive trips and blocks
  always @(posedge sys_clk_i) begin
    {prot_blocked_o, prot_trip_o, comm_in_o, prot_out_o, virt_in_o, fkey_o,
     dig_in_o} <= cmd_i;
  end
endmodule

`default_nettype wire

// ==== tb/programmable_logic_chain_counter_tb_top.sv ====
// Self-checking bench of the programmable logic and counter engine
`default_nettype none

module programmable_logic_chain_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [45:0] cmd = 46'h0;
  logic [3:0] var_en = 4'hF;
  logic [79:0] op = 80'h0;
  logic [23:0] fsel = 24'h0;
  logic [119:0] ssel = 120'h0;
  logic [11:0] csrc = 12'h010;
  logic [11:0] cclr = 12'h011;
  logic [1:0] cust = 2'h0;
  logic [63:0] thr = 64'h0;
  logic [63:0] pre = 64'h0;
  logic [47:0] rsel = 48'h0;
  wire logic [9:0] di;
  wire logic [3:0] key;
  wire logic [3:0] vi;
  wire logic [7:0] po;
  wire logic [3:0] ci;
  wire logic [7:0] pt;
  wire logic [7:0] pb;
  logic [3:0] var_out;
  logic [63:0] cnt_value;
  logic [1:0] cnt_alarm;
  logic any_trip;
  logic any_blocked;
  logic [7:0] route;
  logic cycle_strobe;
  int error_cnt = 0;
  int n_compared = 0;

  plc_src_model src (
    .sys_clk_i(sys_clk), .cmd_i(cmd), .dig_in_o(di), .fkey_o(key),
    .virt_in_o(vi), .prot_out_o(po), .comm_in_o(ci), .prot_trip_o(pt),
    .prot_blocked_o(pb)
  );

  // Short evaluation cycle keeps the run brief
  plc_logic_engine #(.CYCLE_CLKS(4)) uut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .prot_out_i(po),
    .prot_trip_i(pt), .prot_blocked_i(pb), .fkey_i(key), .dig_in_i(di),
    .virt_in_i(vi), .comm_in_i(ci), .var_en_i(var_en), .stage_op_i(op),
    .first_sel_i(fsel), .second_sel_i(ssel), .cnt_src_sel_i(csrc),
    .cnt_clr_sel_i(cclr), .cnt_custom_i(cust), .cnt_alarm_thr_i(thr),
    .cnt_preset_i(pre), .route_sel_i(rsel), .var_out_o(var_out),
    .cnt_value_o(cnt_value), .cnt_alarm_o(cnt_alarm), .any_trip_o(any_trip),
    .any_blocked_o(any_blocked), .route_o(route),
    .cycle_strobe_o(cycle_strobe)
  );

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic final_report();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for n evaluation edges, then settles to the next falling edge
  task automatic sw(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge sys_clk);
        k++;
      end while (cycle_strobe !== 1'b1 && k < 20);
      if (cycle_strobe !== 1'b1) begin
        error_cnt++;
        $display("Error cycle_strobe expected 1 seen %b", cycle_strobe);
      end
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
  endtask

  task automatic ev(input logic [45:0] v, input int n);
    @(posedge sys_clk);
    cmd <= v;
    sw(n);
  endtask

  task automatic st(input int v, input int s, input logic [3:0] o,
                    input logic [5:0] b);
    @(posedge sys_clk);
    op[(v*5+s)*4+:4] <= o;
    ssel[(v*5+s)*6+:6] <= b;
  endtask

  task automatic pulse(input logic [45:0] v);
    ev(v, 1);
    ev(46'h0, 1);
  endtask

  function automatic logic gexp(input int o, input logic a, input logic b);
    case (o)
      1: return a | b;
      2: return ~(a | b);
      3: return a & b;
      4: return ~(a & b);
      5: return a ^ b;
      6: return ~(a ^ b);
      7: return ~a;
      default: return a;
    endcase
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_sources();
    for (int j = 0; j < 30; j++) begin
      @(posedge sys_clk);
      fsel[17:12] <= 6'(j);
      rsel[5:0] <= 6'(j);
      ev(46'h1 << j, 3);
      chk("var_out2", 32'h1, 32'(var_out[2]));
      chk("route0", 32'h1, 32'(route[0]));
      ev(46'h0, 3);
      chk("var_out2", 32'h0, 32'(var_out[2]));
    end
  endtask

  task automatic t_flags();
    @(posedge sys_clk);
    rsel[47:42] <= 6'h1E;
    for (int i = 0; i < 16; i++) begin
      ev(46'h1 << (30 + i), 2);
      chk("any_trip", 32'(i < 8), 32'(any_trip));
      chk("any_blocked", 32'(i >= 8), 32'(any_blocked));
      chk("route7", 32'(i < 8), 32'(route[7]));
    end
  endtask

  task automatic t_gates();
    @(posedge sys_clk);
    fsel[5:0] <= 6'h0E;
    for (int o = 0; o < 8; o++) begin
      st(0, 0, 4'(o), 6'h0F);
      for (int i = 0; i < 4; i++) begin
        ev(46'(i) << 14, 2);
        chk("gate", 32'(gexp(o, i[0], i[1])), 32'(var_out[0]));
      end
    end
  endtask

  task automatic t_chain();
    logic e;
    @(posedge sys_clk);
    fsel[11:6] <= 6'h0E;
    st(1, 1, 4'h3, 6'h0F);
    st(1, 2, 4'h7, 6'h10);
    st(1, 3, 4'h1, 6'h10);
    st(1, 4, 4'h5, 6'h11);
    for (int i = 0; i < 16; i++) begin
      ev(46'(i) << 14, 2);
      // One-bit variable keeps the inversion from widening to 32 bits
      e = (~(i[0] & i[1]) | i[2]) ^ i[3];
      chk("chain", 32'(e), 32'(var_out[1]));
    end
  endtask

  task automatic t_latch();
    logic [9:0] seq;
    logic [4:0] ex;
    seq = 10'h321;
    for (int m = 0; m < 2; m++) begin
      st(0, 0, m ? 4'h9 : 4'h8, 6'h0F);
      ex = m ? 5'h13 : 5'h03;
      for (int i = 0; i < 5; i++) begin
        ev(46'(seq[i*2+:2]) << 14, 2);
        chk("latch", 32'(ex[i]), 32'(var_out[0]));
      end
    end
    @(posedge sys_clk);
    var_en[0] <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("disabled", 32'h0, 32'(var_out[0]));
    ev(46'h1 << 14, 2);
    chk("disabled", 32'h0, 32'(var_out[0]));
  endtask

  task automatic t_toggle();
    logic [3:0] ta;
    logic [3:0] tb;
    logic [3:0] ex;
    ta = 4'hB;
    tb = 4'hD;
    ex = 4'h9;
    st(0, 0, 4'hA, 6'h0F);
    // Drop the input while still disabled: a stale high would toggle at once
    ev(46'h0, 1);
    @(posedge sys_clk);
    var_en[0] <= 1'b1;
    ev(46'h0, 2);
    chk("toggle", 32'h0, 32'(var_out[0]));
    for (int i = 0; i < 4; i++) begin
      ev(46'({tb[i], ta[i]}) << 14, 1);
      chk("toggle", 32'(ex[i]), 32'(var_out[0]));
    end
  endtask

  task automatic t_counter();
    @(posedge sys_clk);
    cust[0] <= 1'b1;
    thr[31:0] <= 32'h00000003;
    ev(46'h0, 2);
    pulse(46'h1 << 17);
    chk("cnt_clear", 32'h0, cnt_value[31:0]);
    for (int k = 1; k < 4; k++) begin
      pulse(46'h1 << 16);
      chk("cnt_value", 32'(k), cnt_value[31:0]);
      chk("cnt_alarm", 32'(k >= 3), 32'(cnt_alarm[0]));
    end
    @(posedge sys_clk);
    pre[31:0] <= 32'hFFFFFFFE;
    ev(46'h0, 2);
    pulse(46'h3 << 16);
    chk("cnt_preset", 32'hFFFFFFFE, cnt_value[31:0]);
    repeat (2) begin
      pulse(46'h1 << 16);
      chk("cnt_sat", 32'hFFFFFFFF, cnt_value[31:0]);
    end
    // Port threshold 0 and preset near max must both be ignored now
    @(posedge sys_clk);
    cust[0] <= 1'b0;
    thr[31:0] <= 32'h00000000;
    ev(46'h0, 2);
    chk("alarm_dflt", 32'h1, 32'(cnt_alarm[0]));
    pulse(46'h1 << 17);
    chk("preset_dflt", 32'h0, cnt_value[31:0]);
    chk("alarm_dflt", 32'h0, 32'(cnt_alarm[0]));
    // Counter 1 counts and clears on one source, so the clear always wins
    chk("cnt1_value", 32'h0, cnt_value[63:32]);
  endtask

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_sources();
    t_flags();
    t_gates();
    t_chain();
    t_latch();
    t_toggle();
    t_counter();
    final_report();
  end

  // The tests need about 1500 clocks; this leaves wide margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    final_report();
  end
endmodule

`default_nettype wire
